// File: common/dcc_pkg.sv
// How it works
// - a vehicle in a zone raises its call within 112 ms, here within cycles
// - every call output owns a selectable timing function of four kinds
// - continuous delay: delay timer runs while occupied, phase state ignored
// - normal delay: delay timer held during assigned green, unless inhibit is disabled
// - extend: call stays on for extend time after vehicle leaves, then drops
// - delay-then-extend: call accepted only once the delay timer has timed out
// - delay-then-extend: call held until zone empty and extend time expired
// - delay-then-extend: re-entry during extend holds call and restarts extend fully
// - delay-then-extend: after extend expiry, delay must time out before next call
// - each zone is presence, directional presence, pulse or directional pulse
// - eight zones and eight independent call outputs per camera
// - zones may overlap; each evaluated on its own, one vehicle hits many
// - camera or power failure forces constant calls on every output
// - zone occupancy is refreshed at least 30 times a second
// - zone and call settings stay editable and new values replace old ones
package dcc_pkg;

    // ********************************
    // sizes
    // ********************************
    localparam int NUM_ZONES = 8;
    localparam int NUM_CALLS = 8;
    localparam int TMR_W     = 8;
    localparam int ADDR_W    = 8;

    // ********************************
    // register map (byte addresses)
    // ********************************
    localparam logic [ADDR_W-1:0] REG_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h04;
    localparam logic [ADDR_W-1:0] REG_ZTYPE     = 8'h08;
    localparam logic [ADDR_W-1:0] REG_ZDIR      = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_CALL0     = 8'h10;
    localparam logic [ADDR_W-1:0] REG_CALL_LAST = 8'h2c;
    localparam logic [ADDR_W-1:0] REG_TSTATE    = 8'h30;
    localparam logic [ADDR_W-1:0] REG_FRAMES    = 8'h34;

    // field positions and reset values
    localparam int CTRL_ENABLE_BIT    = 0;
    localparam int CTRL_NOINH_BIT     = 1;
    localparam int ST_CALL_LSB        = 0;
    localparam int ST_ZONE_LSB        = 8;
    localparam int ST_FRAME_FAIL_BIT  = 16;
    localparam int ST_FAILSAFE_BIT    = 17;
    localparam logic [31:0] CTRL_RST     = 32'h0000_0001;
    localparam logic [15:0] ZTYPE_RST    = 16'h0000;
    localparam logic [7:0]  ZDIR_RST     = 8'h00;
    localparam logic [31:0] CALL_CFG_RST = 32'h0000_0000;

    // ********************************
    // timing
    // ********************************
    localparam int CLK_HZ           = 125_000_000;
    localparam int TICK_MS          = 100;
    localparam int TICK_CYCLES      = CLK_HZ / 1000 * TICK_MS;
    localparam int MIN_FRAME_RATE   = 30;
    localparam int FRAME_MAX_CYCLES = CLK_HZ / MIN_FRAME_RATE;
    localparam int PULSE_MS         = 100;
    localparam int PULSE_CYCLES     = CLK_HZ / 1000 * PULSE_MS;

    // ********************************
    // types
    // ********************************
    typedef enum logic [1:0] {
        MODE_FULL_DELAY = 2'h0,
        MODE_NORM_DELAY = 2'h1,
        MODE_EXTEND     = 2'h2,
        MODE_DELAY_EXT  = 2'h3
    } dcc_mode_t;

    typedef enum logic [1:0] {
        ZT_PRESENCE     = 2'h0,
        ZT_DIR_PRESENCE = 2'h1,
        ZT_PULSE        = 2'h2,
        ZT_DIR_PULSE    = 2'h3
    } dcc_ztype_t;

    typedef enum logic [2:0] {
        TS_IDLE   = 3'h0,
        TS_DELAY  = 3'h1,
        TS_ON     = 3'h2,
        TS_EXTEND = 3'h3,
        TS_REARM  = 3'h4
    } dcc_tstate_t;

    typedef struct packed {
        logic [7:0]       zone_mask;
        logic [TMR_W-1:0] extend;
        logic [TMR_W-1:0] delay;
        logic [5:0]       rsvd;
        dcc_mode_t        mode;
    } dcc_call_cfg_t;

    typedef struct packed {
        logic occ;
        logic dir_fwd;
    } dcc_zone_t;

endpackage : dcc_pkg

// File: hw/dcc_call_timer.sv
`timescale 1ns/10ps
`default_nettype none
module dcc_call_timer
    import dcc_pkg::*;
(
    // clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          ce,
    // time base and detection
    input  wire logic          tick,
    input  wire logic          det,
    input  wire logic          green,
    input  wire logic          inhibit_ok,
    input  wire dcc_call_cfg_t cfg,
    // result
    output logic               call,
    output dcc_tstate_t        state
);

    dcc_tstate_t      state_q;
    logic [TMR_W-1:0] cnt_q;
    logic             done;
    logic             hold;

    // count reaches its end on a tick at one, or at once when loaded zero
    assign done = (cnt_q == '0) || (tick && (cnt_q == 8'h01));
    assign hold = (cfg.mode == MODE_NORM_DELAY) && green && inhibit_ok;

    // ********************************
    // timing state machine
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= TS_IDLE;
            cnt_q   <= '0;
        end else if (ce) begin
            case (state_q)
                TS_IDLE: begin
                    if (det) begin
                        if (cfg.mode == MODE_EXTEND) begin
                            state_q <= TS_ON;
                        end else begin
                            cnt_q   <= cfg.delay;
                            state_q <= TS_DELAY;
                        end
                    end
                end
                TS_DELAY: begin
                    if (!det) begin
                        state_q <= TS_IDLE;
                    end else if (hold) begin
                        state_q <= TS_DELAY;
                    end else if (done) begin
                        state_q <= TS_ON;
                    end else if (tick) begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                TS_ON: begin
                    if (!det) begin
                        if (cfg.mode == MODE_EXTEND || cfg.mode == MODE_DELAY_EXT) begin
                            cnt_q   <= cfg.extend;
                            state_q <= TS_EXTEND;
                        end else begin
                            state_q <= TS_IDLE;
                        end
                    end
                end
                TS_EXTEND: begin
                    if (det) begin
                        state_q <= TS_ON; // full reload when it leaves again
                    end else if (done) begin
                        if (cfg.mode == MODE_DELAY_EXT) begin
                            cnt_q   <= cfg.delay;
                            state_q <= TS_REARM;
                        end else begin
                            state_q <= TS_IDLE;
                        end
                    end else if (tick) begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                TS_REARM: begin
                    // delay runs free here; a waiting vehicle is taken at expiry
                    if (done) begin
                        state_q <= det ? TS_ON : TS_IDLE;
                    end else if (tick) begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: begin
                    state_q <= TS_IDLE;
                end
            endcase
        end
    end

    assign call  = (state_q == TS_ON) || (state_q == TS_EXTEND);
    assign state = state_q;

endmodule : dcc_call_timer
`default_nettype wire

// File: hw/dcc_detector_cond.sv
`timescale 1ns/10ps
`default_nettype none
module dcc_detector_cond
    import dcc_pkg::*;
#(
    parameter int unsigned TICK_CYC  = TICK_CYCLES,
    parameter int unsigned FRAME_CYC = FRAME_MAX_CYCLES,
    parameter int unsigned PULSE_CYC = PULSE_CYCLES
) (
    // clock, reset, enable
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  ce,
    // apb slave
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // video analysis results
    input  wire logic                  frame_stb,
    input  wire dcc_zone_t [NUM_ZONES-1:0] zone_in,
    input  wire logic                  cam_fail,
    input  wire logic                  power_fail,
    // signal controller side
    input  wire logic [NUM_CALLS-1:0]  phase_green,
    output logic [NUM_CALLS-1:0]       call_out,
    output logic                       failsafe
);

    localparam int TCW = $clog2(TICK_CYC + 1);
    localparam int FCW = $clog2(FRAME_CYC + 1);
    localparam int PCW = $clog2(PULSE_CYC + 1);

    // ********************************
    // declarations
    // ********************************
    logic [31:0]              ctrl_q;
    logic [15:0]              ztype_q;
    logic [7:0]               zdir_q;
    dcc_call_cfg_t            call_cfg_q [NUM_CALLS];
    logic [31:0]              prdata_q;
    logic [TCW-1:0]           tcnt_q;
    logic                     tick;
    logic [FCW-1:0]           fcnt_q;
    logic                     frame_fail_q;
    logic [15:0]              frames_q;
    logic                     failsafe_q;
    logic [NUM_CALLS-1:0]     call_q;
    logic [NUM_ZONES-1:0]     zocc_q;
    logic [NUM_ZONES-1:0]     zfwd_q;
    logic [NUM_ZONES-1:0]     zqual;
    logic [NUM_ZONES-1:0]     zqual_prev_q;
    logic [NUM_ZONES-1:0]     zact;
    logic [NUM_CALLS-1:0]     det;
    logic [NUM_CALLS-1:0]     tcall;
    dcc_tstate_t              tstate [NUM_CALLS];
    logic                     acc;
    logic                     wr;
    logic                     setup;
    logic                     call_hit;
    logic [2:0]               call_idx;
    logic                     addr_ok;
    logic [31:0]              rmux;
    logic [31:0]              tstate_word;

    // byte-lane merge of a write into an existing word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // ********************************
    // apb decode
    // ********************************
    // zero wait states; a low clock enable stretches every access
    assign pready   = ce;
    assign setup    = psel && !penable && ce;
    assign acc      = psel && penable && ce;
    assign wr       = acc && pwrite;
    assign call_hit = (paddr >= REG_CALL0) && (paddr <= REG_CALL_LAST) && (paddr[1:0] == 2'b00);
    assign call_idx = 3'((paddr - REG_CALL0) >> 2);
    assign addr_ok  = call_hit || paddr == REG_CTRL || paddr == REG_STATUS || paddr == REG_ZTYPE
                      || paddr == REG_ZDIR || paddr == REG_TSTATE || paddr == REG_FRAMES;
    assign pslverr  = psel && penable && !addr_ok;

    // per-call state readback, three bits a call
    always_comb begin
        tstate_word = '0;
        for (int c = 0; c < NUM_CALLS; c++) begin
            tstate_word[c*3 +: 3] = tstate[c];
        end
    end

    // read mux, sampled in the setup phase so prdata comes from a flop
    always_comb begin
        rmux = '0;
        if (call_hit) begin
            rmux = call_cfg_q[call_idx];
        end else begin
            case (paddr)
                REG_CTRL:   rmux = ctrl_q;
                REG_STATUS: begin
                    rmux[ST_CALL_LSB +: NUM_CALLS] = call_q;
                    rmux[ST_ZONE_LSB +: NUM_ZONES] = zact;
                    rmux[ST_FRAME_FAIL_BIT]        = frame_fail_q;
                    rmux[ST_FAILSAFE_BIT]          = failsafe_q;
                end
                REG_ZTYPE:  rmux = {16'h0000, ztype_q};
                REG_ZDIR:   rmux = {24'h000000, zdir_q};
                REG_TSTATE: rmux = tstate_word;
                REG_FRAMES: rmux = {16'h0000, frames_q};
                default:    rmux = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (setup && !pwrite) begin
            prdata_q <= rmux;
        end
    end

    assign prdata = prdata_q;

    // ********************************
    // configuration registers
    // ********************************
    // settings are rewritten in place at any time and act from the next cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
        end else if (wr && paddr == REG_CTRL) begin
            ctrl_q <= merge(ctrl_q, pwdata, pstrb) & 32'h0000_0003;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ztype_q <= ZTYPE_RST;
        end else if (wr && paddr == REG_ZTYPE) begin
            ztype_q <= 16'(merge({16'h0000, ztype_q}, pwdata, pstrb));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zdir_q <= ZDIR_RST;
        end else if (wr && paddr == REG_ZDIR) begin
            zdir_q <= 8'(merge({24'h000000, zdir_q}, pwdata, pstrb));
        end
    end

    // ********************************
    // time base
    // ********************************
    // one tick per timer unit; delay and extend count in these units
    assign tick = (tcnt_q == TCW'(TICK_CYC - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcnt_q <= '0;
        end else if (ce) begin
            tcnt_q <= tick ? '0 : tcnt_q + 1'b1;
        end
    end

    // ********************************
    // frame watchdog
    // ********************************
    // a silent video path is treated like a failed camera
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fcnt_q       <= '0;
            frame_fail_q <= 1'b0;
        end else if (ce) begin
            if (frame_stb) begin
                fcnt_q       <= '0;
                frame_fail_q <= 1'b0;
            end else if (fcnt_q >= FCW'(FRAME_CYC - 1)) begin
                frame_fail_q <= 1'b1;
            end else begin
                fcnt_q <= fcnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frames_q <= '0;
        end else if (ce && frame_stb) begin
            frames_q <= frames_q + 16'h0001;
        end
    end

    // ********************************
    // zone evaluation
    // ********************************
    // occupancy and direction refresh once per frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zocc_q <= '0;
            zfwd_q <= '0;
        end else if (ce && frame_stb) begin
            for (int z = 0; z < NUM_ZONES; z++) begin
                zocc_q[z] <= zone_in[z].occ;
                zfwd_q[z] <= zone_in[z].dir_fwd;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zqual_prev_q <= '0;
        end else if (ce) begin
            zqual_prev_q <= zqual;
        end
    end

    // each zone stands alone, so overlapping zones all see the same car
    for (genvar z = 0; z < NUM_ZONES; z++) begin : g_zone
        dcc_ztype_t     zt;
        logic [PCW-1:0] pcnt_q;
        logic           is_dir;
        logic           is_pulse;

        assign zt       = dcc_ztype_t'(ztype_q[z*2 +: 2]);
        assign is_dir   = (zt == ZT_DIR_PRESENCE) || (zt == ZT_DIR_PULSE);
        assign is_pulse = (zt == ZT_PULSE) || (zt == ZT_DIR_PULSE);
        // opposite travel is simply not occupancy for this zone
        assign zqual[z] = zocc_q[z] && (!is_dir || (zfwd_q[z] == zdir_q[z]));

        // fixed-length pulse from the cycle clock, not the coarse tick
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pcnt_q <= '0;
            end else if (ce) begin
                if (zqual[z] && !zqual_prev_q[z]) begin
                    pcnt_q <= PCW'(PULSE_CYC);
                end else if (pcnt_q != '0) begin
                    pcnt_q <= pcnt_q - 1'b1;
                end
            end
        end

        assign zact[z] = is_pulse ? (pcnt_q != '0) : zqual[z];
    end

    // ********************************
    // call channels
    // ********************************
    for (genvar c = 0; c < NUM_CALLS; c++) begin : g_call
        // default mapping ties call c to zone c
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                call_cfg_q[c] <= CALL_CFG_RST | {8'(32'd1 << c), 24'h000000};
            end else if (wr && call_hit && call_idx == 3'(c)) begin
                call_cfg_q[c] <= merge(call_cfg_q[c], pwdata, pstrb) & 32'hffff_ff03;
            end
        end

        // any mapped zone raises the call; zones are not exclusive
        assign det[c] = |(call_cfg_q[c].zone_mask & zact);

        dcc_call_timer u_timer (
            .pclk       (pclk),
            .presetn    (presetn),
            .ce         (ce),
            .tick       (tick),
            .det        (det[c]),
            .green      (phase_green[c]),
            .inhibit_ok (!ctrl_q[CTRL_NOINH_BIT]),
            .cfg        (call_cfg_q[c]),
            .call       (tcall[c]),
            .state      (tstate[c])
        );
    end

    // ********************************
    // fail-safe and outputs
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            failsafe_q <= 1'b0;
        end else if (ce) begin
            failsafe_q <= cam_fail || power_fail || frame_fail_q;
        end
    end

    // a handful of cycles from frame to pin, far inside the arrival budget
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            call_q <= '0;
        end else if (ce) begin
            if (failsafe_q) begin
                call_q <= '1;
            end else if (ctrl_q[CTRL_ENABLE_BIT]) begin
                call_q <= tcall;
            end else begin
                call_q <= '0;
            end
        end
    end

    assign call_out = call_q;
    assign failsafe = failsafe_q;

endmodule : dcc_detector_cond
`default_nettype wire

// File: test/dcc_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module dcc_ctrl_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // calls in, phase greens out
    input  wire logic [7:0] call_out,
    input  wire logic [7:0] green_set,
    output logic      [7:0] phase_green,
    output int              calls_seen
);
    logic [7:0] prev_q;

    // greens come from the bench's phase plan, one flop late like a real controller
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_green <= 8'h00;
            prev_q      <= 8'h00;
            calls_seen  <= 0;
        end else begin
            phase_green <= green_set;
            prev_q      <= call_out;
            calls_seen  <= calls_seen + $countones(call_out & ~prev_q);
        end
    end
endmodule : dcc_ctrl_model
`default_nettype wire

// File: test/dcc_detector_cond_chk.sv
`timescale 1ns/10ps
`default_nettype none
module dcc_detector_cond_chk
    import dcc_pkg::*;
(
    // clock and reset
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 ce,
    // apb
    input wire logic [ADDR_W-1:0]    paddr,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    // detection and calls
    input wire logic                 frame_stb,
    input wire logic                 cam_fail,
    input wire logic                 power_fail,
    input wire logic [NUM_CALLS-1:0] call_out,
    input wire logic                 failsafe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ready; pready == ce; endproperty
    property p_err_phase; pslverr |-> psel && penable; endproperty
    property p_err_map; psel && penable && paddr > 8'h34 |-> pslverr; endproperty
    // prdata only moves in a read setup cycle
    property p_rd_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
    property p_fs_set; (cam_fail || power_fail) && ce |=> failsafe; endproperty
    property p_fs_calls; failsafe && ce |=> call_out == 8'hff; endproperty
    // two clean cycles, one with a frame, are needed before the flop can drop
    property p_fs_clear;
        frame_stb && !cam_fail && !power_fail && ce ##1 !cam_fail && !power_fail && ce |=> !failsafe;
    endproperty
    property p_ce_hold; !ce |=> $stable(call_out) && $stable(failsafe); endproperty

    a_ready: assert property (p_ready) else $error("pready differs from ce");
    a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
    a_err_map: assert property (p_err_map) else $error("unmapped access accepted");
    a_rd_hold: assert property (p_rd_hold) else $error("prdata moved");
    a_fs_set: assert property (p_fs_set) else $error("failsafe not raised");
    a_fs_calls: assert property (p_fs_calls) else $error("failsafe calls missing");
    a_fs_clear: assert property (p_fs_clear) else $error("failsafe stuck");
    a_ce_hold: assert property (p_ce_hold) else $error("state moved with ce low");

    c_fs: cover property ($rose(failsafe));
    c_err: cover property (pslverr);
    c_call: cover property ($rose(call_out[0]));
endmodule : dcc_detector_cond_chk

bind dcc_detector_cond dcc_detector_cond_chk u_chk (.pclk, .presetn, .ce, .paddr, .psel, .penable, .pwrite,
    .prdata, .pready, .pslverr, .frame_stb, .cam_fail, .power_fail, .call_out, .failsafe);
`default_nettype wire

// File: test/detector_call_conditioning_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module detector_call_conditioning_tb_top;
    import dcc_pkg::*;
    logic pclk, presetn, ce, psel, penable, pwrite, frame_stb, cam_fail, power_fail, frames_on, pready, pslverr;
    logic failsafe, sl_q;
    logic [7:0] paddr, call_out, green_set, phase_green;
    logic [31:0] pwdata, prdata, rd_q;
    dcc_zone_t [NUM_ZONES-1:0] zone_in;
    int err_count, comparisons, i, n, seen;

    dcc_detector_cond #(.TICK_CYC(10), .FRAME_CYC(200), .PULSE_CYC(5)) dut (.pclk, .presetn, .ce, .paddr,
        .psel, .penable, .pwrite, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .frame_stb, .zone_in,
        .cam_fail, .power_fail, .phase_green, .call_out, .failsafe);
    dcc_ctrl_model u_ctrl (.pclk, .presetn, .call_out, .green_set, .phase_green, .calls_seen(seen));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // a frame every 8 cycles
    initial forever begin
        repeat (7) @(posedge pclk);
        frame_stb <= frames_on;
        @(posedge pclk);
        frame_stb <= 1'b0;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        stop_test();
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_q = prdata;
        sl_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wcall(input int c, input logic v, input int lim);
        int k;
        for (k = 0; k < lim && call_out[c] !== v; k++) @(posedge pclk);
        chk("call_out", v, call_out[c]);
    endtask : wcall
    task automatic hold(input int c, input logic v, input int cyc);
        int k, bad;
        bad = 0;
        for (k = 0; k < cyc; k++) begin
            @(posedge pclk);
            if (call_out[c] !== v) bad++;
        end
        chk("call_hold", 0, bad);
    endtask : hold
    task automatic zs(input logic [15:0] v);
        zone_in <= v;
    endtask : zs
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test

    // ********************************
    // tests
    // ********************************
    initial begin
        {presetn, psel, penable, pwrite, frame_stb, cam_fail, power_fail} = '0;
        {ce, frames_on} = 2'b11;
        {paddr, pwdata, green_set, zone_in} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, REG_CTRL, 0);
        chk("ctrl", CTRL_RST, rd_q);
        for (i = 0; i < NUM_CALLS; i++) begin
            apb(0, REG_CALL0 + 8'(i * 4), 0);
            chk("call_cfg", 32'h0100_0000 << i, rd_q);
        end
        apb(1, REG_CALL0 + 8'h0c, 32'hff12_34fe);
        apb(0, REG_CALL0 + 8'h0c, 0);
        chk("call_edit", 32'hff12_3402, rd_q);
        apb(1, REG_CALL0 + 8'h0c, 32'h0800_0000);
        apb(0, 8'h38, 0);
        chk("pslverr", 1, sl_q);
        chk("prdata", 0, rd_q);
        $display("test registers done");
        zs(16'h000a);
        wcall(0, 1, 40);
        wcall(1, 1, 5);
        chk("other_calls", 0, call_out[7:2]);
        ce <= 1'b0;
        zs(0);
        hold(0, 1, 20);
        ce <= 1'b1;
        wcall(0, 0, 40);
        $display("test presence done");
        green_set <= 8'h01;
        apb(1, REG_CALL0, 32'h0100_0301);
        zs(2);
        hold(0, 0, 100);
        apb(1, REG_CTRL, 3);
        wcall(0, 1, 60);
        apb(1, REG_CTRL, 2);
        wcall(0, 0, 5);
        apb(1, REG_CTRL, 3);
        wcall(0, 1, 5);
        zs(0);
        wcall(0, 0, 40);
        apb(1, REG_CTRL, 1);
        apb(1, REG_CALL0, 32'h0100_0300);
        zs(2);
        hold(0, 0, 12);
        wcall(0, 1, 60);
        zs(0);
        wcall(0, 0, 40);
        green_set <= 8'h00;
        $display("test delay done");
        apb(1, REG_CALL0, 32'h0103_0002);
        zs(2);
        wcall(0, 1, 40);
        zs(0);
        hold(0, 1, 18);
        wcall(0, 0, 40);
        $display("test extend done");
        apb(1, REG_CALL0, 32'h0103_0203);
        zs(2);
        hold(0, 0, 10);
        wcall(0, 1, 60);
        zs(0);
        repeat (10) @(posedge pclk);
        zs(2);
        hold(0, 1, 40);
        zs(0);
        hold(0, 1, 18);
        wcall(0, 0, 60);
        zs(2);
        hold(0, 0, 8);
        wcall(0, 1, 40);
        zs(0);
        wcall(0, 0, 60);
        repeat (30) @(posedge pclk);
        $display("test combined done");
        apb(1, REG_CALL0, 32'h0100_0000);
        apb(1, REG_ZDIR, 1);
        for (i = 1; i < 4; i++) begin
            apb(1, REG_ZTYPE, i);
            zs(2);
            if (i != 2) hold(0, 0, 40);
            if (i == 2) wcall(0, 1, 40);
            zs(3);
            wcall(0, 1, 40);
            for (n = 0; i > 1 && n < 50 && call_out[0] === 1'b1; n++) @(posedge pclk);
            if (i > 1) chk("pulse_short", 1, n <= 8);
            if (i > 1) hold(0, 0, 30);
            zs(0);
            wcall(0, 0, 40);
            repeat (20) @(posedge pclk);
        end
        $display("test zone types done");
        apb(1, REG_ZTYPE, 0);
        cam_fail <= 1'b1;
        wcall(5, 1, 5);
        chk("fs_calls", 8'hff, call_out);
        apb(0, REG_STATUS, 0);
        chk("status_fs", 1, rd_q[ST_FAILSAFE_BIT]);
        cam_fail <= 1'b0;
        wcall(5, 0, 10);
        power_fail <= 1'b1;
        wcall(3, 1, 5);
        power_fail <= 1'b0;
        wcall(3, 0, 10);
        frames_on <= 1'b0;
        wcall(2, 1, 260);
        frames_on <= 1'b1;
        wcall(2, 0, 30);
        chk("ctrl_saw_calls", 1, seen > 10);
        $display("test failsafe done");
        stop_test();
    end
endmodule : detector_call_conditioning_tb_top
`default_nettype wire
